// ### hw/mbt_pkg.sv
// Package of constants, types and test phase tables for the memory self-test and debug channel block.
//
// How it works
// R1: Each debug word has a flag set by a write and cleared by a read.
// R2: Both debug words stay readable and writable while the device is protected.
// R3: While protected the reset extension bit is locked and the CPU is held in reset.
// R4: The host leaves the debug words alone while a self-test runs.
// R5: A start from outside while protected is refused and sets the protection error.
// R6: Phase one writes zero to every byte of the range.
// R7: Phase two, bits descending: read zero, write one.
// R8: Phase three, bits ascending: read one, write zero, read zero, write one.
// R9: Phase four, bits ascending: read one, write zero.
// R10: Phase five, bits ascending: read zero, write one, read one, write zero.
// R11: The last phase reads every byte ascending and expects zero.
// R12: The host loads start address and byte count before starting.
// R13: Writing one to the start bit runs the test over the loaded range.
// R14: Writing one to the software reset bit aborts a running test.
// R15: When a run ends the done flag in the primary status is set.
// R16: The host should test a whole physical memory block in one run.
// R17: Any read mismatch sets a failure flag; the run still completes.
// R18: Identification registers are read-only and ignore writes.
`default_nettype none

package mbt_pkg;

  localparam int unsigned ADDR_W = 13;
  localparam int unsigned MEM_W  = 8;

  localparam logic [12:0] OFF_CTRL    = 13'h000;
  localparam logic [12:0] OFF_ST_PRI  = 13'h004;
  localparam logic [12:0] OFF_ST_SEC  = 13'h008;
  localparam logic [12:0] OFF_ADDR    = 13'h00c;
  localparam logic [12:0] OFF_LEN     = 13'h010;
  localparam logic [12:0] OFF_DCC_A   = 13'h014;
  localparam logic [12:0] OFF_DCC_B   = 13'h018;
  localparam logic [12:0] OFF_INT_ST  = 13'h01c;
  localparam logic [12:0] OFF_INT_CLR = 13'h020;
  localparam logic [12:0] OFF_INT_EN  = 13'h024;
  localparam logic [12:0] OFF_MEMORY_TYPE_INFO = 13'h1fcc;
  localparam logic [12:0] OFF_PERIPHERAL_IDENT_WORD4    = 13'h1fd0;
  localparam logic [12:0] OFF_PERIPHERAL_IDENT_WORD0    = 13'h1fe0;
  localparam logic [12:0] OFF_PERIPHERAL_IDENT_WORD1    = 13'h1fe4;
  localparam logic [12:0] OFF_PERIPHERAL_IDENT_WORD2    = 13'h1fe8;
  localparam logic [12:0] OFF_PERIPHERAL_IDENT_WORD3    = 13'h1fec;
  localparam logic [12:0] OFF_COMPONENT_IDENT_WORD0    = 13'h1ff0;
  localparam logic [12:0] OFF_COMPONENT_IDENT_WORD1    = 13'h1ff4;
  localparam logic [12:0] OFF_COMPONENT_IDENT_WORD2    = 13'h1ff8;
  localparam logic [12:0] OFF_COMPONENT_IDENT_WORD3    = 13'h1ffc;

  // Identification contents; every value below is arbitrary.
  localparam logic [31:0] ID_MEMORY_TYPE_INFO = 32'h0000_0001;
  localparam logic [31:0] ID_PERIPHERAL_IDENT_WORD4    = 32'h0000_0012;
  localparam logic [31:0] ID_PERIPHERAL_IDENT_WORD0    = 32'h0000_0034;
  localparam logic [31:0] ID_PERIPHERAL_IDENT_WORD1    = 32'h0000_0056;
  localparam logic [31:0] ID_PERIPHERAL_IDENT_WORD2    = 32'h0000_0078;
  localparam logic [31:0] ID_PERIPHERAL_IDENT_WORD3    = 32'h0000_009a;
  localparam logic [31:0] ID_COMPONENT_IDENT_WORD0    = 32'h0000_00bc;
  localparam logic [31:0] ID_COMPONENT_IDENT_WORD1    = 32'h0000_00de;
  localparam logic [31:0] ID_COMPONENT_IDENT_WORD2    = 32'h0000_00f1;
  localparam logic [31:0] ID_COMPONENT_IDENT_WORD3    = 32'h0000_0023;

  localparam int unsigned CTRL_SOFTWARE_RESET_BIT  = 0;
  localparam int unsigned CTRL_START  = 1;
  localparam int unsigned PRI_DONE    = 0;
  localparam int unsigned PRI_FAIL    = 1;
  localparam int unsigned PRI_PROTECTION_ERROR_FLAG    = 2;
  localparam int unsigned PRI_CPU_RESET_EXTENSION = 3;
  localparam int unsigned SEC_FLAG_A  = 0;
  localparam int unsigned SEC_FLAG_B  = 1;
  localparam int unsigned SEC_PROT    = 2;
  localparam int unsigned SEC_BUSY    = 3;
  localparam int unsigned INT_DONE    = 0;
  localparam int unsigned INT_PROTECTION_ERROR_FLAG    = 1;
  localparam int unsigned INT_FLAG_A  = 2;
  localparam int unsigned INT_FLAG_B  = 3;
  localparam int unsigned INT_W       = 4;

  localparam logic [2:0] PH_FILL = 3'd0;
  localparam logic [2:0] PH_DESC = 3'd1;
  localparam logic [2:0] PH_LAST = 3'd5;
  localparam logic [2:0] BIT_TOP = 3'd7;
  localparam logic       CRST_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    MBT_IDLE = 3'b001,
    MBT_RUN  = 3'b010,
    MBT_CHK  = 3'b100
  } mbt_state_t;

  typedef struct packed {
    logic             req;
    logic             we;
    logic [31:0]      addr;
    logic [MEM_W-1:0] wdata;
  } mbt_mem_req_t;

  typedef struct packed {
    logic is_wr;
    logic val;
    logic last;
  } mbt_op_t;

  // One march element per phase: the op sequence applied at every bit or byte.
  function automatic mbt_op_t mbt_op(input logic [2:0] ph, input logic [1:0] idx);
    mbt_op_t o;
    o = '{is_wr: idx[0], val: 1'b0, last: 1'b0};
    case (ph)
      3'd0: o = '{is_wr: 1'b1, val: 1'b0, last: 1'b1};
      3'd1: o = '{is_wr: idx[0], val: idx[0], last: idx[0]};
      3'd2: o = '{is_wr: idx[0], val: ~(idx[0] ^ idx[1]), last: &idx};
      3'd3: o = '{is_wr: idx[0], val: ~idx[0], last: idx[0]};
      3'd4: o = '{is_wr: idx[0], val: idx[0] ^ idx[1], last: &idx};
      3'd5: o = '{is_wr: 1'b0, val: 1'b0, last: 1'b1};
      default: o = '{is_wr: 1'b0, val: 1'b0, last: 1'b1};
    endcase
    return o;
  endfunction

endpackage : mbt_pkg

`default_nettype wire

// ### hw/mbt_top.sv
// Memory self-test engine, debug word registers, identification map and AXI4-Lite slave.
//
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none

module mbt_top (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [12:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [12:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  dev_protected,
  input  wire logic                  ext_access,
  output logic                       cpu_hold_reset,
  output logic                       irq,
  output mbt_pkg::mbt_mem_req_t      mem_o,
  input  wire logic [7:0]            mem_rdata
);

  logic                  prot_m_q, prot_q, ext_m_q, ext_q;
  logic                  aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [12:0]           awaddr_q;
  logic [31:0]           wdata_q, rdata_q;
  logic [3:0]            wstrb_q;
  logic [1:0]            bresp_q, rresp_q;
  logic [31:0]           addr_q, len_q, dcc_a_q, dcc_b_q, off_q;
  logic                  flag_a_q, flag_b_q, done_q, fail_q, protection_error_flag_q, crst_q, end_q;
  logic [mbt_pkg::INT_W-1:0] int_st_q, int_en_q;
  mbt_pkg::mbt_state_t   state_q;
  logic [2:0]            phase_q, bit_q;
  logic [1:0]            op_q;
  logic [7:0]            work_q, exp_q;
  logic [31:0]           fail_addr_q;

  // Pins from outside the clock domain pass two flip-flops before use.
  always_ff @(posedge clk) begin
    if (rst) begin
      prot_m_q <= 1'b0;
      prot_q   <= 1'b0;
      ext_m_q  <= 1'b0;
      ext_q    <= 1'b0;
    end else begin
      prot_m_q <= dev_protected;
      prot_q   <= prot_m_q;
      ext_m_q  <= ext_access;
      ext_q    <= ext_m_q;
    end
  end

  // Write channel: address and data are taken in either order, then applied together.
  wire         aw_fire = s_axi_awvalid & s_axi_awready;
  wire         w_fire  = s_axi_wvalid & s_axi_wready;
  wire         do_wr   = aw_hold_q & w_hold_q & ~bvalid_q;
  wire [31:0]  wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire         wlow    = do_wr & wstrb_q[0];
  wire         wr_ctrl = wlow & (awaddr_q == mbt_pkg::OFF_CTRL);
  wire         wr_pri  = wlow & (awaddr_q == mbt_pkg::OFF_ST_PRI);
  wire         wr_addr = do_wr & (awaddr_q == mbt_pkg::OFF_ADDR);
  wire         wr_len  = do_wr & (awaddr_q == mbt_pkg::OFF_LEN);
  wire         wr_dcca = do_wr & (awaddr_q == mbt_pkg::OFF_DCC_A);
  wire         wr_dccb = do_wr & (awaddr_q == mbt_pkg::OFF_DCC_B);
  wire         wr_iclr = wlow & (awaddr_q == mbt_pkg::OFF_INT_CLR);
  wire         wr_ien  = wlow & (awaddr_q == mbt_pkg::OFF_INT_EN);
  wire         wr_id   = awaddr_q >= mbt_pkg::OFF_MEMORY_TYPE_INFO;
  wire         wr_map  = (awaddr_q <= mbt_pkg::OFF_INT_EN) & (awaddr_q[1:0] == 2'b00);
  wire         software_reset_bit   = wr_ctrl & wdata_q[mbt_pkg::CTRL_SOFTWARE_RESET_BIT];
  wire         start   = wr_ctrl & wdata_q[mbt_pkg::CTRL_START] & ~software_reset_bit;
  wire         refuse  = start & prot_q & ext_q;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= mbt_pkg::RESP_OKAY;
      awaddr_q  <= 13'h0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        // Writes to identification words are ignored but answered OKAY. (see R18)
        bresp_q   <= (wr_map | wr_id) ? mbt_pkg::RESP_OKAY : mbt_pkg::RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel with one-cycle answer.
  wire         ar_fire = s_axi_arvalid & s_axi_arready;
  wire         rd_dcca = ar_fire & (s_axi_araddr == mbt_pkg::OFF_DCC_A);
  wire         rd_dccb = ar_fire & (s_axi_araddr == mbt_pkg::OFF_DCC_B);
  wire         busy    = state_q != mbt_pkg::MBT_IDLE;
  logic [31:0] rd_c;
  logic        rd_err_c;

  always_comb begin
    rd_c     = 32'h0000_0000;
    rd_err_c = 1'b0;
    case (s_axi_araddr)
      mbt_pkg::OFF_CTRL:    rd_c = 32'h0000_0000;
      mbt_pkg::OFF_ST_PRI:  rd_c = {28'h0000000, crst_q, protection_error_flag_q, fail_q, done_q};
      mbt_pkg::OFF_ST_SEC:  rd_c = {28'h0000000, busy, prot_q, flag_b_q, flag_a_q};
      mbt_pkg::OFF_ADDR:    rd_c = addr_q;
      mbt_pkg::OFF_LEN:     rd_c = len_q;
      mbt_pkg::OFF_DCC_A:   rd_c = dcc_a_q;
      mbt_pkg::OFF_DCC_B:   rd_c = dcc_b_q;
      mbt_pkg::OFF_INT_ST:  rd_c = {28'h0000000, int_st_q};
      mbt_pkg::OFF_INT_EN:  rd_c = {28'h0000000, int_en_q};
      mbt_pkg::OFF_MEMORY_TYPE_INFO: rd_c = mbt_pkg::ID_MEMORY_TYPE_INFO;
      mbt_pkg::OFF_PERIPHERAL_IDENT_WORD4:    rd_c = mbt_pkg::ID_PERIPHERAL_IDENT_WORD4;
      mbt_pkg::OFF_PERIPHERAL_IDENT_WORD0:    rd_c = mbt_pkg::ID_PERIPHERAL_IDENT_WORD0;
      mbt_pkg::OFF_PERIPHERAL_IDENT_WORD1:    rd_c = mbt_pkg::ID_PERIPHERAL_IDENT_WORD1;
      mbt_pkg::OFF_PERIPHERAL_IDENT_WORD2:    rd_c = mbt_pkg::ID_PERIPHERAL_IDENT_WORD2;
      mbt_pkg::OFF_PERIPHERAL_IDENT_WORD3:    rd_c = mbt_pkg::ID_PERIPHERAL_IDENT_WORD3;
      mbt_pkg::OFF_COMPONENT_IDENT_WORD0:    rd_c = mbt_pkg::ID_COMPONENT_IDENT_WORD0;
      mbt_pkg::OFF_COMPONENT_IDENT_WORD1:    rd_c = mbt_pkg::ID_COMPONENT_IDENT_WORD1;
      mbt_pkg::OFF_COMPONENT_IDENT_WORD2:    rd_c = mbt_pkg::ID_COMPONENT_IDENT_WORD2;
      mbt_pkg::OFF_COMPONENT_IDENT_WORD3:    rd_c = mbt_pkg::ID_COMPONENT_IDENT_WORD3;
      mbt_pkg::OFF_INT_CLR: rd_c = 32'h0000_0000;
      default:              rd_err_c = 1'b1;
    endcase
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= mbt_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_c;
      rresp_q  <= rd_err_c ? mbt_pkg::RESP_SLVERR : mbt_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Engine decode: march op, bit index, address and data for the current step.
  mbt_pkg::mbt_op_t op_c;
  assign op_c = mbt_pkg::mbt_op(phase_q, op_q);
  wire         bitwise  = (phase_q != mbt_pkg::PH_FILL) & (phase_q != mbt_pkg::PH_LAST);
  wire         desc     = phase_q == mbt_pkg::PH_DESC;
  wire [2:0]   bidx     = desc ? (mbt_pkg::BIT_TOP - bit_q) : bit_q;
  wire [7:0]   bmask    = 8'h01 << bidx;
  wire [31:0]  lenm1    = len_q - 32'h0000_0001;
  wire [31:0]  moff     = desc ? (lenm1 - off_q) : off_q;
  wire         last_bit = ~bitwise | (bit_q == mbt_pkg::BIT_TOP);
  wire         last_off = off_q == lenm1;
  wire         last_ph  = phase_q == mbt_pkg::PH_LAST;
  wire         all_last = op_c.last & last_bit & last_off & last_ph;
  wire         new_byte = (bit_q == 3'd0) & (op_q == 2'd0);
  wire [7:0]   cur_work = new_byte ? {8{op_c.val}} : work_q;
  wire [7:0]   bit_wr   = op_c.val ? (cur_work | bmask) : (cur_work & ~bmask);
  wire [7:0]   step_dat = bitwise ? bit_wr : {8{op_c.val}};
  wire         running  = state_q == mbt_pkg::MBT_RUN;
  wire         mismatch = (state_q == mbt_pkg::MBT_CHK) & (mem_rdata != exp_q);
  wire         finish   = ~software_reset_bit & ((running & op_c.is_wr & all_last) |
                                    ((state_q == mbt_pkg::MBT_CHK) & end_q));
  wire         launch   = start & ~refuse & ~busy;

  assign mem_o.req   = running & ~software_reset_bit;
  assign mem_o.we    = op_c.is_wr;
  assign mem_o.addr  = addr_q + moff;
  assign mem_o.wdata = bitwise ? bit_wr : {8{op_c.val}}; // see R6 R7 R8 R9 R10

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= mbt_pkg::MBT_IDLE;
      phase_q <= 3'd0;
      op_q    <= 2'd0;
      bit_q   <= 3'd0;
      off_q   <= 32'h0000_0000;
      work_q  <= 8'h00;
      exp_q   <= 8'h00;
      end_q   <= 1'b0;
    end else if (software_reset_bit) begin
      state_q <= mbt_pkg::MBT_IDLE; // see R14
    end else if (launch) begin
      // A zero length has nothing to test and ends at once. (see R13)
      state_q <= (len_q == 32'h0000_0000) ? mbt_pkg::MBT_IDLE : mbt_pkg::MBT_RUN;
      phase_q <= 3'd0;
      op_q    <= 2'd0;
      bit_q   <= 3'd0;
      off_q   <= 32'h0000_0000;
      end_q   <= 1'b0;
    end else if (running) begin
      work_q  <= step_dat;
      exp_q   <= cur_work; // see R7 R8 R9 R10 R11
      end_q   <= all_last;
      state_q <= op_c.is_wr ? (all_last ? mbt_pkg::MBT_IDLE : mbt_pkg::MBT_RUN) : mbt_pkg::MBT_CHK;
      op_q    <= op_c.last ? 2'd0 : op_q + 2'd1;
      if (op_c.last) begin
        bit_q <= last_bit ? 3'd0 : bit_q + 3'd1;
        if (last_bit) begin
          off_q <= last_off ? 32'h0000_0000 : off_q + 32'h0000_0001;
          if (last_off) begin
            phase_q <= phase_q + 3'd1;
          end
        end
      end
    end else if (state_q == mbt_pkg::MBT_CHK) begin
      state_q <= end_q ? mbt_pkg::MBT_IDLE : mbt_pkg::MBT_RUN;
    end
  end

  // Read address of the byte under check, kept for failure capture.
  always_ff @(posedge clk) begin
    if (rst) begin
      fail_addr_q <= 32'h0000_0000;
    end else if (running) begin
      fail_addr_q <= mem_o.addr;
    end
  end

  // Status, debug words and interrupts. Hardware sets win over clears in the same cycle.
  wire [mbt_pkg::INT_W-1:0] ev = {wr_dccb, wr_dcca, refuse, finish | (launch & (len_q == 32'h0000_0000))};

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q   <= 32'h0000_0000;
      len_q    <= 32'h0000_0000;
      dcc_a_q  <= 32'h0000_0000;
      dcc_b_q  <= 32'h0000_0000;
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
      done_q   <= 1'b0;
      fail_q   <= 1'b0;
      protection_error_flag_q   <= 1'b0;
      crst_q   <= mbt_pkg::CRST_RESET;
      int_st_q <= '0;
      int_en_q <= '0;
    end else begin
      if (wr_addr) addr_q <= (addr_q & ~wmask) | (wdata_q & wmask);
      if (wr_len) len_q <= (len_q & ~wmask) | (wdata_q & wmask);
      // The debug words stay open in the protected state. (see R2)
      if (wr_dcca) dcc_a_q <= (dcc_a_q & ~wmask) | (wdata_q & wmask);
      else if (mismatch & ~fail_q) dcc_a_q <= fail_addr_q; // see R17
      if (wr_dccb) dcc_b_q <= (dcc_b_q & ~wmask) | (wdata_q & wmask);
      else if (mismatch & ~fail_q) dcc_b_q <= {16'h0000, exp_q, mem_rdata};
      flag_a_q <= wr_dcca | (flag_a_q & ~rd_dcca); // see R1
      flag_b_q <= wr_dccb | (flag_b_q & ~rd_dccb); // see R1
      done_q   <= ev[mbt_pkg::INT_DONE] | (done_q & ~launch & ~(wr_pri & wdata_q[mbt_pkg::PRI_DONE])); // see R15
      fail_q   <= mismatch | (fail_q & ~launch & ~(wr_pri & wdata_q[mbt_pkg::PRI_FAIL])); // see R17
      protection_error_flag_q   <= refuse | (protection_error_flag_q & ~(wr_pri & wdata_q[mbt_pkg::PRI_PROTECTION_ERROR_FLAG])); // see R5
      // Protection locks the extension so no debugger attaches to a running CPU.
      if (wr_pri & wdata_q[mbt_pkg::PRI_CPU_RESET_EXTENSION] & ~prot_q) crst_q <= 1'b0; // see R3
      if (wr_ien) int_en_q <= wdata_q[mbt_pkg::INT_W-1:0];
      int_st_q <= ev | (int_st_q & ~(wr_iclr ? wdata_q[mbt_pkg::INT_W-1:0] : '0));
    end
  end

  assign cpu_hold_reset = crst_q | prot_q; // see R3
  assign irq            = |(int_st_q & int_en_q);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_flag_a_set: assert property (wr_dcca |=> flag_a_q) else $error("flag a not set"); // see R1
  chk_flag_b_clr: assert property (rd_dccb & ~wr_dccb |=> ~flag_b_q) else $error("flag b not cleared"); // see R1
  chk_dcc_prot: assert property (wr_dcca & prot_q & (&wstrb_q) |=> dcc_a_q == $past(wdata_q))
    else $error("debug word blocked"); // see R2
  chk_cpu_held: assert property (prot_q |-> cpu_hold_reset & $stable(crst_q) [*2])
    else $error("cpu not held"); // see R3
  chk_refuse_protection_error_flag: assert property (refuse |=> protection_error_flag_q & ~busy) else $error("start not refused"); // see R5
  chk_fill_zero: assert property (mem_o.req & phase_q == 3'd0 |-> mem_o.we & mem_o.wdata == 8'h00)
    else $error("fill not zero"); // see R6
  chk_desc_bit: assert property (mem_o.req & desc & mem_o.we |-> mem_o.wdata[bidx] & bidx == 3'd7 - bit_q)
    else $error("descending write bad"); // see R7
  chk_ph3_seq: assert property (mem_o.req & phase_q == 3'd2 & op_q == 2'd0 |-> ##2 mem_o.req & mem_o.we
    & ~mem_o.wdata[bidx]) else $error("phase three write bad"); // see R8
  chk_ph4_write: assert property (mem_o.req & phase_q == 3'd3 & mem_o.we |-> ~mem_o.wdata[bidx])
    else $error("phase four write bad"); // see R9
  chk_ph5_write: assert property (mem_o.req & phase_q == 3'd4 & mem_o.we |-> mem_o.wdata[bidx] == ~op_q[1])
    else $error("phase five write bad"); // see R10
  chk_final_read: assert property (mem_o.req & last_ph |-> ~mem_o.we ##1 exp_q == 8'h00)
    else $error("final read bad"); // see R11
  chk_start_run: assert property (launch & len_q != 32'h0 |=> mem_o.req & mem_o.addr == addr_q)
    else $error("run not started"); // see R13
  chk_abort: assert property (software_reset_bit |-> ~mem_o.req ##1 ~busy) else $error("abort failed"); // see R14
  chk_done_set: assert property (finish |=> done_q & ~busy) else $error("done missing"); // see R15
  chk_fail_flag: assert property (mismatch |=> fail_q) else $error("fail not flagged"); // see R17
  chk_id_ro: assert property (ar_fire & s_axi_araddr == mbt_pkg::OFF_PERIPHERAL_IDENT_WORD0 |=> rdata_q == mbt_pkg::ID_PERIPHERAL_IDENT_WORD0)
    else $error("id changed"); // see R18

endmodule // mbt_top

`default_nettype wire

// ### verification/mbt_ram_model.sv
// Byte-wide synchronous RAM behind the self-test engine, with one injectable stuck-at-one fault.
`default_nettype none

module mbt_ram_model (
  input  wire logic                  clk,
  input  wire mbt_pkg::mbt_mem_req_t mem_i,
  input  wire logic [7:0]            stuck_addr,
  input  wire logic [7:0]            stuck_mask,
  output logic [7:0]                 rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last_q;
  logic       rd_q;
  wire  [7:0] idx = mem_i.addr[7:0];

  // Start from a non-zero pattern so that a skipped fill phase shows up.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h5a;
    end
    last_q = 8'h00;
    rd_q = 1'b0;
  end

  // Read data stands for one cycle only; otherwise the port shows the inverse.
  always_ff @(posedge clk) begin
    rd_q <= mem_i.req & ~mem_i.we;
    if (mem_i.req && mem_i.we) mem[idx] <= mem_i.wdata;
    if (mem_i.req && !mem_i.we) last_q <= mem[idx] | ((idx == stuck_addr) ? stuck_mask : 8'h00);
  end
  assign rdata = rd_q ? last_q : ~last_q;
endmodule // mbt_ram_model

`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the memory self-test and debug word block.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0, rst = 1'b1, prot = 1'b0, ext = 1'b0;
  logic [12:0]           awaddr = 13'h0000, araddr = 13'h0000;
  logic [31:0]           wdata = 32'h0000_0000, rdata, v;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid, hold, irq;
  logic [1:0]            bresp, rresp, r;
  logic [7:0]            s_addr = 8'h00, s_mask = 8'h00, mrd;
  mbt_pkg::mbt_mem_req_t mem_o;
  int                    errors = 0, cmp_count = 0, cyc = 0;

  mbt_top dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dev_protected(prot), .ext_access(ext), .cpu_hold_reset(hold), .irq(irq),
    .mem_o(mem_o), .mem_rdata(mrd));
  mbt_ram_model ram_u (.clk(clk), .mem_i(mem_o), .stuck_addr(s_addr), .stuck_mask(s_mask), .rdata(mrd));

  always #4 clk = ~clk;
  // A hung handshake ends the run here with a mismatch counted; a poll gives up after 500 reads.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Handshakes are judged on settled values before the edge, so no race with the slave's flops.
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      b_hit = (bvalid === 1'b1);
      if (b_hit) r = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end while (!b_hit);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [12:0] a);
    logic ar_hit, r_hit;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_hit = arvalid & arready;
      r_hit = (rvalid === 1'b1);
      if (r_hit) begin
        v = rdata;
        r = rresp;
      end
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
    end while (!r_hit);
    rready <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(mbt_pkg::OFF_ST_PRI);
      n++;
    end while (v[mbt_pkg::PRI_DONE] !== 1'b1 && n < 500);
  endtask

  task automatic t_reset_id();
    logic [12:0] oa [10];
    logic [31:0] ia [10];
    oa = '{13'h1fcc, 13'h1fd0, 13'h1fe0, 13'h1fe4, 13'h1fe8, 13'h1fec, 13'h1ff0, 13'h1ff4, 13'h1ff8, 13'h1ffc};
    ia = '{mbt_pkg::ID_MEMORY_TYPE_INFO, mbt_pkg::ID_PERIPHERAL_IDENT_WORD4, mbt_pkg::ID_PERIPHERAL_IDENT_WORD0, mbt_pkg::ID_PERIPHERAL_IDENT_WORD1, mbt_pkg::ID_PERIPHERAL_IDENT_WORD2,
           mbt_pkg::ID_PERIPHERAL_IDENT_WORD3, mbt_pkg::ID_COMPONENT_IDENT_WORD0, mbt_pkg::ID_COMPONENT_IDENT_WORD1, mbt_pkg::ID_COMPONENT_IDENT_WORD2, mbt_pkg::ID_COMPONENT_IDENT_WORD3};
    chk("hold", hold, 1'b1);
    rd(mbt_pkg::OFF_ST_PRI);
    chk("pri", v, 32'h0000_0008);
    for (int i = 0; i < 10; i++) begin
      wr(oa[i], ~ia[i]);
      rd(oa[i]);
      chk("id", v, ia[i]);
    end
    rd(13'h0100);
    chk("unmapped", {v[29:0], r}, {30'h0, mbt_pkg::RESP_SLVERR});
  endtask

  task automatic t_prot();
    prot <= 1'b1;
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    wr(mbt_pkg::OFF_ST_PRI, 32'h0000_0008);
    rd(mbt_pkg::OFF_ST_PRI);
    chk("crst", {hold, v}, {1'b1, 32'h0000_0008});
    wr(mbt_pkg::OFF_DCC_A, 32'h1234_5678);
    rd(mbt_pkg::OFF_ST_SEC);
    chk("flag set", v, 32'h0000_0005);
    rd(mbt_pkg::OFF_DCC_A);
    chk("word a", v, 32'h1234_5678);
    rd(mbt_pkg::OFF_ST_SEC);
    chk("flag clr", v, 32'h0000_0004);
    wr(mbt_pkg::OFF_CTRL, 32'h0000_0002);
    rd(mbt_pkg::OFF_ST_PRI);
    chk("protection_error_flag", v, 32'h0000_000c);
    chk("irq masked", irq, 1'b0);
    wr(mbt_pkg::OFF_INT_EN, 32'h0000_0002);
    chk("irq on", irq, 1'b1);
    wr(mbt_pkg::OFF_INT_CLR, 32'h0000_0002);
    chk("irq off", irq, 1'b0);
    prot <= 1'b0;
    ext <= 1'b0;
    repeat (4) @(posedge clk);
    wr(mbt_pkg::OFF_ST_PRI, 32'h0000_000c);
    wr(mbt_pkg::OFF_DCC_B, 32'h0000_00aa);
    rd(mbt_pkg::OFF_ST_SEC);
    chk("flag b", {hold, v}, {1'b0, 32'h0000_0002});
  endtask

  // The four bytes stand in for one whole small block; the debug words are left alone while busy.
  task automatic t_march();
    wr(mbt_pkg::OFF_ADDR, 32'h0000_0010);
    wr(mbt_pkg::OFF_LEN, 32'h0000_0004);
    wr(mbt_pkg::OFF_CTRL, 32'h0000_0002);
    rd(mbt_pkg::OFF_ST_SEC);
    chk("busy", v[mbt_pkg::SEC_BUSY], 1'b1);
    wait_done();
    chk("pass", v, 32'h0000_0001);
    for (int i = 16; i < 20; i++) chk("ram", ram_u.mem[i], 8'h00);
    chk("outside", ram_u.mem[20], 8'h5a);
    wr(mbt_pkg::OFF_INT_EN, 32'h0000_0001);
    chk("irq done", irq, 1'b1);
    wr(mbt_pkg::OFF_INT_CLR, 32'h0000_0001);
    chk("irq clr", irq, 1'b0);
    s_addr <= 8'h11;
    s_mask <= 8'h02;
    wr(mbt_pkg::OFF_CTRL, 32'h0000_0002);
    wait_done();
    chk("fail", v, 32'h0000_0003);
    rd(mbt_pkg::OFF_DCC_A);
    chk("fail addr", v, 32'h0000_0011);
    s_mask <= 8'h00;
  endtask

  // A long run is cut off early, so no done flag may appear.
  task automatic t_abort();
    wr(mbt_pkg::OFF_LEN, 32'h0000_0040);
    wr(mbt_pkg::OFF_CTRL, 32'h0000_0002);
    repeat (20) @(posedge clk);
    wr(mbt_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("req", mem_o.req, 1'b0);
    rd(mbt_pkg::OFF_ST_SEC);
    chk("idle", v[mbt_pkg::SEC_BUSY], 1'b0);
    rd(mbt_pkg::OFF_ST_PRI);
    chk("no done", v[mbt_pkg::PRI_DONE], 1'b0);
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_id();
    t_prot();
    t_march();
    t_abort();
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
